/* core/uart_baud_pkg.sv */
`default_nettype none
package uart_baud_pkg;

  // Register byte addresses on the plain register port
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_SERIAL_CONTROL = 8'h98;
  localparam logic [7:0] ADDR_BRG_RELOAD = 8'h9a;
  localparam logic [7:0] ADDR_BAUD_CONTROL = 8'h9b;
  localparam logic [7:0] ADDR_TIMER2_CONTROL = 8'hc8;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'he8;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'he9;

  // Serial control field positions
  localparam int SC_BIT7 = 7;
  localparam int SC_MODE_ONE = 6;
  localparam int SC_MULTIPROC = 5;
  localparam int SC_RX_ALLOW = 4;
  localparam int SC_TX_NINTH = 3;
  localparam int SC_RX_NINTH = 2;
  localparam int SC_TX_DONE = 1;
  localparam int SC_RX_DONE = 0;

  // Baud control field positions
  localparam int BC_RUN = 4;
  localparam int BC_TX_BRG = 3;
  localparam int BC_RX_BRG = 2;
  localparam int BC_FAST = 1;
  localparam int BC_SHIFT_SRC = 0;

  // Timer 2 control and power control field positions
  localparam int T2_RX_SEL = 5;
  localparam int T2_TX_SEL = 4;
  localparam int PC_DOUBLER = 7;
  localparam int PC_ERR_VIEW = 6;

  // Interrupt status and mask field positions
  localparam int IRQ_TX = 0;
  localparam int IRQ_RX = 1;
  localparam int IRQ_FE = 2;
  localparam int IRQ_BITS = 3;

  // Values after reset
  localparam logic [7:0] SERIAL_CONTROL_RESET = 8'h00;
  localparam logic [7:0] BRG_RELOAD_RESET = 8'h00;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  // Divisors held as count limit (divisor minus one); BRG_TOP is the reload counter top
  localparam logic [5:0] SHIFT_LIMIT_STD = 6'd11;
  localparam logic [5:0] SHIFT_LIMIT_X2 = 6'd5;
  localparam logic [5:0] FIXED9_LIMIT_STD = 6'd63;
  localparam logic [5:0] FIXED9_LIMIT_DBL = 6'd31;
  localparam logic [2:0] BRG_PRESCALE_LIMIT = 3'd5;
  localparam logic [4:0] OVF_LIMIT_STD = 5'd31;
  localparam logic [4:0] OVF_LIMIT_DBL = 5'd15;
  localparam logic [4:0] T2_OVF_LIMIT = 5'd15;
  localparam logic [7:0] BRG_TOP = 8'hff;

  // Serial port operating modes
  typedef enum logic [1:0] {
    MODE_SHIFT,
    MODE_UART8_VAR,
    MODE_UART9_FIXED,
    MODE_UART9_VAR
  } mode_t;

endpackage
`default_nettype wire

/* core/event_divider.sv */
`default_nettype none
module event_divider #(
  parameter int WIDTH = 6
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic [WIDTH-1:0] limit_i,
  output logic tick_o
);

  logic [WIDTH-1:0] count_reg;

  // Counts enabled events, one tick per limit plus one events
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      count_reg <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (en_i) begin
        if (count_reg >= limit_i) begin
          count_reg <= '0;
          tick_o <= 1'b1;
        end else begin
          count_reg <= count_reg + 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* core/uart_baud_select_and_control.sv */
// The address-and-strobe port was left to the implementer.
`default_nettype none
module uart_baud_select_and_control (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Clock sources and strap
  input wire logic timer1_ovf_i,
  input wire logic timer2_ovf_i,
  input wire logic double_speed_mode_i,
  // Events from the shift datapath
  input wire logic tx_bit8_end_i,
  input wire logic tx_stop_begin_i,
  input wire logic rx_bit8_end_i,
  input wire logic rx_data_end_i,
  input wire logic rx_stop_i,
  input wire logic rx_stop_level_i,
  input wire logic rx_ninth_i,
  input wire logic rx_addr_match_i,
  // Controls to the shift datapath
  output logic tx_bit_tick_o,
  output logic rx_bit_tick_o,
  output uart_baud_pkg::mode_t mode_o,
  output logic receive_enable_o,
  output logic tx_ninth_bit_o,
  output logic multiproc_o,
  output logic frame_check_o,
  output logic irq_o
);
  import uart_baud_pkg::*;

  logic mode_bit_zero_reg, mode_bit_one_reg, multiproc_enable_reg, receive_allow_reg;
  logic tx_ninth_bit_reg, rx_ninth_bit_reg, transmit_done_flag_reg, receive_done_flag_reg;
  logic frame_error_flag_reg;
  logic [7:0] brg_reload_value_reg;
  logic brg_run_reg, tx_brg_select_reg, rx_brg_select_reg, brg_fast_select_reg, brg_shift_mode_select_reg;
  logic tx_timer2_select_reg, rx_timer2_select_reg;
  logic baud_doubler_reg, error_bit_view_select_reg;
  logic [IRQ_BITS-1:0] irq_status_reg, irq_mask_reg;
  logic [7:0] brg_count_reg;
  logic [2:0] brg_pre_reg;
  logic brg_ovf_reg;
  mode_t mode;
  logic fixed_tick, tx_var_tick, rx_var_tick;
  logic tx_src_ovf, rx_src_ovf;
  logic [4:0] tx_limit, rx_limit, ovf_limit;
  logic [5:0] fixed_limit;
  logic brg_step;
  logic wr_sc, wr_irq_status;
  logic tx_event, rx_event, rx_accept, fe_event;
  logic [7:0] serial_control_view;

  ////////////////////////////////////////////////////////////////
  // Mode decode and write decode

  always_comb begin
    unique case ({mode_bit_zero_reg, mode_bit_one_reg})
      2'b00: mode = MODE_SHIFT;
      2'b01: mode = MODE_UART8_VAR;
      2'b10: mode = MODE_UART9_FIXED;
      2'b11: mode = MODE_UART9_VAR;
    endcase
  end

  assign wr_sc = wr_i && (addr_i == ADDR_SERIAL_CONTROL);
  assign wr_irq_status = wr_i && (addr_i == ADDR_IRQ_STATUS);

  ////////////////////////////////////////////////////////////////
  // Configuration registers

  // Baud control, reload, timer 2 and power control bits
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      brg_reload_value_reg <= BRG_RELOAD_RESET;
      brg_run_reg <= 1'b0;
      tx_brg_select_reg <= 1'b0;
      rx_brg_select_reg <= 1'b0;
      brg_fast_select_reg <= 1'b0;
      brg_shift_mode_select_reg <= 1'b0;
      tx_timer2_select_reg <= 1'b0;
      rx_timer2_select_reg <= 1'b0;
      baud_doubler_reg <= 1'b0;
      error_bit_view_select_reg <= 1'b0;
      irq_mask_reg <= IRQ_RESET;
    end else if (wr_i) begin
      if (addr_i == ADDR_BRG_RELOAD) begin
        brg_reload_value_reg <= wdata_i;
      end
      if (addr_i == ADDR_BAUD_CONTROL) begin
        brg_run_reg <= wdata_i[BC_RUN];
        tx_brg_select_reg <= wdata_i[BC_TX_BRG];
        rx_brg_select_reg <= wdata_i[BC_RX_BRG];
        brg_fast_select_reg <= wdata_i[BC_FAST];
        brg_shift_mode_select_reg <= wdata_i[BC_SHIFT_SRC];
      end
      if (addr_i == ADDR_TIMER2_CONTROL) begin
        tx_timer2_select_reg <= wdata_i[T2_TX_SEL];
        rx_timer2_select_reg <= wdata_i[T2_RX_SEL];
      end
      if (addr_i == ADDR_POWER_CONTROL) begin
        baud_doubler_reg <= wdata_i[PC_DOUBLER];
        error_bit_view_select_reg <= wdata_i[PC_ERR_VIEW];
      end
      if (addr_i == ADDR_IRQ_MASK) begin
        irq_mask_reg <= wdata_i[IRQ_BITS-1:0];
      end
    end
  end

  // Serial control bits that only software changes
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mode_bit_zero_reg <= SERIAL_CONTROL_RESET[SC_BIT7];
      mode_bit_one_reg <= SERIAL_CONTROL_RESET[SC_MODE_ONE];
      multiproc_enable_reg <= SERIAL_CONTROL_RESET[SC_MULTIPROC];
      receive_allow_reg <= SERIAL_CONTROL_RESET[SC_RX_ALLOW];
      tx_ninth_bit_reg <= SERIAL_CONTROL_RESET[SC_TX_NINTH];
    end else if (wr_sc) begin
      if (!error_bit_view_select_reg) begin
        mode_bit_zero_reg <= wdata_i[SC_BIT7];
      end
      mode_bit_one_reg <= wdata_i[SC_MODE_ONE];
      multiproc_enable_reg <= wdata_i[SC_MULTIPROC];
      receive_allow_reg <= wdata_i[SC_RX_ALLOW];
      tx_ninth_bit_reg <= wdata_i[SC_TX_NINTH];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Internal baud generator

  assign brg_step = brg_fast_select_reg || (brg_pre_reg == BRG_PRESCALE_LIMIT);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      brg_pre_reg <= '0;
      brg_count_reg <= BRG_RELOAD_RESET;
      brg_ovf_reg <= 1'b0;
    end else begin
      brg_ovf_reg <= 1'b0;
      if (!brg_run_reg) begin
        brg_pre_reg <= '0;
        brg_count_reg <= brg_reload_value_reg;
      end else begin
        brg_pre_reg <= brg_step ? 3'd0 : brg_pre_reg + 3'd1;
        if (brg_step) begin
          if (brg_count_reg == BRG_TOP) begin
            brg_count_reg <= brg_reload_value_reg;
            brg_ovf_reg <= 1'b1;
          end else begin
            brg_count_reg <= brg_count_reg + 8'h01;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Bit clock selection

  assign fixed_limit = (mode == MODE_SHIFT) ? (double_speed_mode_i ? SHIFT_LIMIT_X2 : SHIFT_LIMIT_STD)
                                            : (baud_doubler_reg ? FIXED9_LIMIT_DBL : FIXED9_LIMIT_STD);

  assign ovf_limit = baud_doubler_reg ? OVF_LIMIT_DBL : OVF_LIMIT_STD;

  assign tx_src_ovf = tx_brg_select_reg ? brg_ovf_reg : (tx_timer2_select_reg ? timer2_ovf_i : timer1_ovf_i);
  assign tx_limit = (!tx_brg_select_reg && tx_timer2_select_reg) ? T2_OVF_LIMIT : ovf_limit;

  assign rx_src_ovf = rx_brg_select_reg ? brg_ovf_reg : (rx_timer2_select_reg ? timer2_ovf_i : timer1_ovf_i);
  assign rx_limit = (!rx_brg_select_reg && rx_timer2_select_reg) ? T2_OVF_LIMIT : ovf_limit;

  event_divider #(.WIDTH(6)) fixed_div (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .en_i(1'b1),
    .limit_i(fixed_limit),
    .tick_o(fixed_tick)
  );

  event_divider #(.WIDTH(5)) tx_div (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .en_i(tx_src_ovf),
    .limit_i(tx_limit),
    .tick_o(tx_var_tick)
  );

  event_divider #(.WIDTH(5)) rx_div (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .en_i(rx_src_ovf),
    .limit_i(rx_limit),
    .tick_o(rx_var_tick)
  );

  // Bit ticks per mode, registered to the datapath
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tx_bit_tick_o <= 1'b0;
      rx_bit_tick_o <= 1'b0;
    end else begin
      unique case (mode)
        MODE_SHIFT: begin
          tx_bit_tick_o <= brg_shift_mode_select_reg ? brg_ovf_reg : fixed_tick;
          rx_bit_tick_o <= brg_shift_mode_select_reg ? brg_ovf_reg : fixed_tick;
        end
        MODE_UART9_FIXED: begin
          tx_bit_tick_o <= fixed_tick;
          rx_bit_tick_o <= fixed_tick;
        end
        MODE_UART8_VAR, MODE_UART9_VAR: begin
          tx_bit_tick_o <= tx_var_tick;
          rx_bit_tick_o <= rx_var_tick;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Hardware flags

  assign tx_event = (mode == MODE_SHIFT) ? tx_bit8_end_i : tx_stop_begin_i;

  // receive done moment; gated by receive allow
  always_comb begin
    if (mode == MODE_SHIFT) begin
      rx_event = receive_allow_reg && rx_bit8_end_i;
    end else begin
      rx_event = receive_allow_reg && (error_bit_view_select_reg ? rx_stop_i : rx_data_end_i);
    end
  end

  always_comb begin
    if (!multiproc_enable_reg || mode == MODE_SHIFT) begin
      rx_accept = 1'b1;
    end else if (mode == MODE_UART8_VAR) begin
      rx_accept = rx_stop_level_i && rx_addr_match_i;
    end else begin
      rx_accept = rx_ninth_i && rx_addr_match_i;
    end
  end

  assign fe_event = receive_allow_reg && error_bit_view_select_reg && rx_stop_i && !rx_stop_level_i &&
                    (mode != MODE_SHIFT);

  // Flags: hardware set wins over software write
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      transmit_done_flag_reg <= SERIAL_CONTROL_RESET[SC_TX_DONE];
      receive_done_flag_reg <= SERIAL_CONTROL_RESET[SC_RX_DONE];
      rx_ninth_bit_reg <= SERIAL_CONTROL_RESET[SC_RX_NINTH];
      frame_error_flag_reg <= 1'b0;
    end else begin
      if (wr_sc) begin
        transmit_done_flag_reg <= wdata_i[SC_TX_DONE];
        receive_done_flag_reg <= wdata_i[SC_RX_DONE];
        rx_ninth_bit_reg <= wdata_i[SC_RX_NINTH];
        if (error_bit_view_select_reg && !wdata_i[SC_BIT7]) begin
          frame_error_flag_reg <= 1'b0;
        end
      end
      if (tx_event) begin
        transmit_done_flag_reg <= 1'b1;
      end
      if (rx_event && rx_accept) begin
        receive_done_flag_reg <= 1'b1;
        if (mode == MODE_UART9_FIXED || mode == MODE_UART9_VAR) begin
          rx_ninth_bit_reg <= rx_ninth_i;
        end else if (mode == MODE_UART8_VAR) begin
          rx_ninth_bit_reg <= rx_stop_level_i;
        end
      end
      if (fe_event) begin
        frame_error_flag_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Interrupt status and output

  // Sticky status, write one to clear, set wins
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_status_reg <= IRQ_RESET;
    end else begin
      irq_status_reg <= (irq_status_reg & ~(wr_irq_status ? wdata_i[IRQ_BITS-1:0] : IRQ_RESET)) |
                        {fe_event, rx_event && rx_accept, tx_event};
    end
  end

  // Level interrupt from unmasked status
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status_reg & irq_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read path and datapath controls

  // bit 7 shows error or mode bit
  assign serial_control_view = {error_bit_view_select_reg ? frame_error_flag_reg : mode_bit_zero_reg,
                                mode_bit_one_reg, multiproc_enable_reg, receive_allow_reg,
                                tx_ninth_bit_reg, rx_ninth_bit_reg, transmit_done_flag_reg,
                                receive_done_flag_reg};

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      unique case (addr_i)
        ADDR_SERIAL_CONTROL: rdata_o <= serial_control_view;
        ADDR_BRG_RELOAD: rdata_o <= brg_reload_value_reg;
        ADDR_BAUD_CONTROL: rdata_o <= {3'h0, brg_run_reg, tx_brg_select_reg, rx_brg_select_reg,
                                       brg_fast_select_reg, brg_shift_mode_select_reg};
        ADDR_TIMER2_CONTROL: rdata_o <= {2'h0, rx_timer2_select_reg, tx_timer2_select_reg, 4'h0};
        ADDR_POWER_CONTROL: rdata_o <= {baud_doubler_reg, error_bit_view_select_reg, 6'h00};
        ADDR_IRQ_STATUS: rdata_o <= {5'h00, irq_status_reg};
        ADDR_IRQ_MASK: rdata_o <= {5'h00, irq_mask_reg};
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // Registered controls to the datapath
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mode_o <= MODE_SHIFT;
      receive_enable_o <= 1'b0;
      tx_ninth_bit_o <= 1'b0;
      multiproc_o <= 1'b0;
      frame_check_o <= 1'b0;
    end else begin
      mode_o <= mode;
      receive_enable_o <= receive_allow_reg;
      // ninth transmit bit in modes 2,3
      tx_ninth_bit_o <= tx_ninth_bit_reg && (mode == MODE_UART9_FIXED || mode == MODE_UART9_VAR);
      multiproc_o <= multiproc_enable_reg && (mode != MODE_SHIFT);
      frame_check_o <= error_bit_view_select_reg && (mode != MODE_SHIFT);
    end
  end

endmodule
`default_nettype wire

/* dv/uart_baud_select_and_control_properties.sv */
`default_nettype none
module uart_baud_checker
  import uart_baud_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic tx_bit8_end_i,
  input wire logic tx_stop_begin_i,
  input wire logic rx_bit8_end_i,
  input wire logic rx_data_end_i,
  input wire logic rx_stop_i,
  input wire logic tx_bit_tick_o,
  input wire logic rx_bit_tick_o,
  input wire uart_baud_pkg::mode_t mode_o,
  input wire logic tx_ninth_bit_o,
  input wire logic multiproc_o,
  input wire logic frame_check_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic ev;
  // Any flag-raising event from the datapath
  assign ev = tx_bit8_end_i | tx_stop_begin_i | rx_bit8_end_i | rx_data_end_i | rx_stop_i;
  chk_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  chk_mp_mode0: assert property (mode_o == MODE_SHIFT |-> !multiproc_o)
    else $error("multiprocessor enabled in shift mode");
  chk_ninth_modes: assert property (mode_o inside {MODE_SHIFT, MODE_UART8_VAR} |-> !tx_ninth_bit_o)
    else $error("ninth bit driven outside nine-bit modes");
  chk_frame_mode0: assert property (mode_o == MODE_SHIFT |-> !frame_check_o)
    else $error("frame check active in shift mode");
  chk_tx_fixed_gap: assert property ((mode_o == MODE_UART9_FIXED && tx_bit_tick_o) |=>
    (!tx_bit_tick_o || mode_o != MODE_UART9_FIXED) [*8])
    else $error("fixed-rate transmit ticks too close");
  chk_rx_fixed_gap: assert property ((mode_o == MODE_UART9_FIXED && rx_bit_tick_o) |=>
    (!rx_bit_tick_o || mode_o != MODE_UART9_FIXED) [*8])
    else $error("fixed-rate receive ticks too close");
  chk_irq_rise_cause: assert property ($rose(irq_o) |->
    ($past(ev) || $past(ev, 2) || $past(wr_i) || $past(wr_i, 2)))
    else $error("interrupt rose without event or write");
  chk_irq_fall_cause: assert property ($fell(irq_o) |-> ($past(wr_i) || $past(wr_i, 2)))
    else $error("interrupt dropped without software write");
endmodule
bind uart_baud_select_and_control uart_baud_checker i_chk (.sys_clk_i, .rst_i, .wr_i, .rd_i, .rdata_o,
  .tx_bit8_end_i, .tx_stop_begin_i, .rx_bit8_end_i, .rx_data_end_i, .rx_stop_i, .tx_bit_tick_o,
  .rx_bit_tick_o, .mode_o, .tx_ninth_bit_o, .multiproc_o, .frame_check_o, .irq_o);
`default_nettype wire

/* dv/timer_overflow_model.sv */
`default_nettype none
module timer_overflow_model #(
  parameter int P1 = 5,
  parameter int P2 = 7
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  output logic timer1_ovf_o,
  output logic timer2_ovf_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int c1;
  int c2;
  // Free-running timers, one-cycle overflow pulse each period
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      c1 <= 0;
      c2 <= 0;
    end else begin
      c1 <= (c1 == P1 - 1) ? 0 : c1 + 1;
      c2 <= (c2 == P2 - 1) ? 0 : c2 + 1;
    end
  end
  assign timer1_ovf_o = !rst_i && c1 == P1 - 1;
  assign timer2_ovf_o = !rst_i && c2 == P2 - 1;
endmodule
`default_nettype wire

/* dv/uart_baud_select_and_control_bench.sv */
`default_nettype none
module uart_baud_select_and_control_bench;
  import uart_baud_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] r; logic [1:0] m;} row_t;
  logic sys_clk_i, rst_i, wr_i, rd_i, dsm, stop_lvl, ninth, match, t1, t2;
  logic tx_tick, rx_tick, rx_en, tx_ninth, mp, fchk, irq_o;
  logic [7:0] addr, wdata, rdata;
  logic [4:0] ev;
  mode_t mode;
  int failures = 0;
  int n_compared = 0;
  int k;
  ////////////////////////////////////////////////////////////////
  // Register rows: address, write value, read-back, mode
  row_t rows [12] = '{'{8'h9a, 8'h5a, 8'h5a, 2'd0}, '{8'h9b, 8'hff, 8'h1f, 2'd0},
    '{8'hc8, 8'hff, 8'h30, 2'd0}, '{8'h87, 8'hff, 8'hc0, 2'd0}, '{8'he9, 8'hff, 8'h07, 2'd0},
    '{8'h3c, 8'hff, 8'h00, 2'd0}, '{8'h87, 8'h00, 8'h00, 2'd0}, '{8'h9b, 8'h00, 8'h00, 2'd0},
    '{8'h98, 8'h40, 8'h40, 2'd1}, '{8'h98, 8'h80, 8'h80, 2'd2}, '{8'h98, 8'hc0, 8'hc0, 2'd3},
    '{8'h98, 8'h00, 8'h00, 2'd0}};
  uart_baud_select_and_control i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .timer1_ovf_i(t1), .timer2_ovf_i(t2),
    .double_speed_mode_i(dsm), .tx_bit8_end_i(ev[0]), .tx_stop_begin_i(ev[1]), .rx_bit8_end_i(ev[2]),
    .rx_data_end_i(ev[3]), .rx_stop_i(ev[4]), .rx_stop_level_i(stop_lvl), .rx_ninth_i(ninth),
    .rx_addr_match_i(match), .tx_bit_tick_o(tx_tick), .rx_bit_tick_o(rx_tick), .mode_o(mode),
    .receive_enable_o(rx_en), .tx_ninth_bit_o(tx_ninth), .multiproc_o(mp), .frame_check_o(fchk),
    .irq_o(irq_o));
  timer_overflow_model i_timers (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .timer1_ovf_o(t1), .timer2_ovf_o(t2));
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    wdata <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  // Read strobe, data taken in the following cycle
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    addr <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    check({8'h00, rdata}, {8'h00, e});
  endtask
  task automatic pulse(input logic [4:0] m);
    @(posedge sys_clk_i);
    ev <= m;
    @(posedge sys_clk_i);
    ev <= 5'h00;
  endtask
  // Measure the gap between two later ticks of one direction
  task automatic per(input bit rx, input int exp);
    int n;
    int p;
    n = 0;
    p = 0;
    repeat (2) begin
      @(posedge sys_clk_i);
      #1;
      while ((rx ? rx_tick : tx_tick) !== 1'b1 && n < 3000) begin
        @(posedge sys_clk_i);
        #1;
        n++;
      end
    end
    do begin
      @(posedge sys_clk_i);
      #1;
      p++;
    end while ((rx ? rx_tick : tx_tick) !== 1'b1 && p < 3000);
    if (n >= 3000 || p >= 3000) begin
      failures++;
      tally_and_finish();
    end
    check(p[15:0], exp[15:0]);
  endtask
  ////////////////////////////////////////////////////////////////
  // Clock at 200 MHz
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  // Main sequence
  initial begin
    {rst_i, wr_i, rd_i, dsm, stop_lvl, ninth, match, addr, wdata, ev} = {1'b1, 27'h0};
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rdchk(8'h98, 8'h00);
    check({15'h0, irq_o}, 16'h0000);
    check({15'h0, rx_en}, 16'h0000);
    $display("reset test done");
    for (int i = 0; i < 12; i++) begin
      wr(rows[i].a, rows[i].w);
      rdchk(rows[i].a, rows[i].r);
      check({14'h0, mode}, {14'h0, rows[i].m});
    end
    $display("register rows done");
    wr(8'h98, 8'h80);
    per(0, 64);
    wr(8'h87, 8'h80);
    per(1, 32);
    wr(8'h87, 8'h00);
    wr(8'h98, 8'h40);
    wr(8'h9a, 8'hfe);
    wr(8'hc8, 8'h30);
    wr(8'h9b, 8'h18);
    per(0, 384);
    per(1, 112);
    wr(8'h9b, 8'h1a);
    per(0, 64);
    wr(8'hc8, 8'h00);
    wr(8'h87, 8'h80);
    per(0, 32);
    per(1, 80);
    wr(8'h9b, 8'h1e);
    per(1, 32);
    wr(8'h9b, 8'h0e);
    repeat (4) @(posedge sys_clk_i);
    k = 0;
    repeat (500) begin
      @(posedge sys_clk_i);
      #1;
      k += tx_tick;
    end
    check(k[15:0], 16'h0000);
    wr(8'h87, 8'h00);
    wr(8'h98, 8'h00);
    per(0, 12);
    @(posedge sys_clk_i);
    dsm <= 1'b1;
    per(0, 6);
    wr(8'h9b, 8'h13);
    per(1, 2);
    wr(8'h9b, 8'h00);
    $display("rate tests done");
    wr(8'h87, 8'h40);
    wr(8'h98, 8'h50);
    pulse(5'h10);
    rdchk(8'h98, 8'hd1);
    check({15'h0, irq_o}, 16'h0001);
    check({15'h0, fchk}, 16'h0001);
    check({15'h0, rx_en}, 16'h0001);
    stop_lvl <= 1'b1;
    pulse(5'h10);
    rdchk(8'h98, 8'hd5);
    wr(8'h98, 8'hd0);
    rdchk(8'h98, 8'hd0);
    pulse(5'h08);
    rdchk(8'h98, 8'hd0);
    wr(8'h98, 8'h50);
    rdchk(8'h98, 8'h50);
    wr(8'he8, 8'h07);
    rdchk(8'he8, 8'h00);
    check({15'h0, irq_o}, 16'h0000);
    wr(8'h98, 8'h40);
    stop_lvl <= 1'b0;
    pulse(5'h18);
    rdchk(8'h98, 8'h40);
    check({15'h0, rx_en}, 16'h0000);
    pulse(5'h02);
    rdchk(8'h98, 8'h42);
    wr(8'h87, 8'h00);
    wr(8'h98, 8'hd8);
    rdchk(8'h98, 8'hd8);
    check({15'h0, tx_ninth}, 16'h0001);
    ninth <= 1'b1;
    pulse(5'h08);
    rdchk(8'h98, 8'hdd);
    wr(8'h98, 8'hf0);
    pulse(5'h08);
    rdchk(8'h98, 8'hf0);
    match <= 1'b1;
    pulse(5'h08);
    rdchk(8'h98, 8'hf5);
    check({15'h0, mp}, 16'h0001);
    wr(8'h98, 8'h30);
    pulse(5'h04);
    rdchk(8'h98, 8'h31);
    check({15'h0, mp}, 16'h0000);
    // Transmit done at the eighth bit in shift mode
    pulse(5'h01);
    rdchk(8'h98, 8'h33);
    // Mode 1 multiprocessor: stop level and match both needed
    wr(8'h98, 8'h70);
    pulse(5'h08);
    rdchk(8'h98, 8'h70);
    stop_lvl <= 1'b1;
    pulse(5'h08);
    rdchk(8'h98, 8'h75);
    wr(8'h98, 8'h48);
    rdchk(8'h98, 8'h48);
    check({15'h0, tx_ninth}, 16'h0000);
    $display("flag tests done");
    check({15'h0, irq_o}, 16'h0001);
    // Reset in mid-run returns every register and output to zero
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rdchk(8'h98, 8'h00);
    rdchk(8'h9a, 8'h00);
    rdchk(8'he9, 8'h00);
    check({15'h0, irq_o}, 16'h0000);
    check({14'h0, mode}, 16'h0000);
    check({15'h0, rx_en}, 16'h0000);
    $display("mid-run reset test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
